// file: lsot_off_timer.v
`timescale 1ns/1ns
`include "lsot_map.vh"

module lsot_off_timer #(
  parameter NUM_SINKS   = 4,
  parameter TICK_CYCLES = `LSOT_TICK_CYCLES
) (
  // Clock and reset.
  input  wire                      ref_clk,
  input  wire                      rst,
  // Register port.
  input  wire [`LSOT_ADDR_W-1:0]   reg_addr,
  input  wire [`LSOT_DATA_W-1:0]   reg_wdata,
  input  wire                      reg_we,
  input  wire                      reg_re,
  output reg  [`LSOT_DATA_W-1:0]   reg_rdata_r,
  // Link to the rest of the sequencer.
  input  wire [`LSOT_ON_CODE_W-1:0] shared_on_time_code,
  input  wire [NUM_SINKS-1:0]      sink_enable,
  input  wire [NUM_SINKS-1:0]      ramp_up_done,
  // Sink drive requests.
  output reg  [NUM_SINKS-1:0]      sink_on_r,
  output reg  [NUM_SINKS-1:0]      sink_off_phase_r
);

  localparam [`LSOT_ST_W-1:0] ST_IDLE = 2'h0;
  localparam [`LSOT_ST_W-1:0] ST_RAMP = 2'h1;
  localparam [`LSOT_ST_W-1:0] ST_ON   = 2'h2;
  localparam [`LSOT_ST_W-1:0] ST_OFF  = 2'h3;

  localparam [`LSOT_CNT_W-1:0] CNT_ONE  = 6'h01;
  localparam [`LSOT_CNT_W-1:0] CNT_ZERO = 6'h00;

  reg  [`LSOT_DATA_W-1:0] sink1_to_4_off_time_r;
  wire                    tick;
  wire [NUM_SINKS-1:0]    on_nxt;
  wire [NUM_SINKS-1:0]    off_nxt;

  // Converts a nonzero off-time code into a count of time-base ticks.
  function [`LSOT_CNT_W-1:0] off_ticks;
    input [`LSOT_CODE_W-1:0] code;
    begin
      case (code)
        `LSOT_OFF_0P6: off_ticks = `LSOT_OFF_TICKS_0P6;
        `LSOT_OFF_1P2: off_ticks = `LSOT_OFF_TICKS_1P2;
        `LSOT_OFF_1P8: off_ticks = `LSOT_OFF_TICKS_1P8;
        default:       off_ticks = CNT_ZERO;
      endcase
    end
  endfunction

  // Picks one sink's code field out of the register.
  function [`LSOT_CODE_W-1:0] sink_code;
    input [`LSOT_DATA_W-1:0] regv;
    input integer            idx;
    begin
      case (idx)
        0:       sink_code = regv[`LSOT_SINK1_LSB +: `LSOT_CODE_W];
        1:       sink_code = regv[`LSOT_SINK2_LSB +: `LSOT_CODE_W];
        2:       sink_code = regv[`LSOT_SINK3_LSB +: `LSOT_CODE_W];
        default: sink_code = regv[`LSOT_SINK4_LSB +: `LSOT_CODE_W];
      endcase
    end
  endfunction

  lsot_timebase #(
    .TICK_CYCLES (TICK_CYCLES),
    .CNT_W       (32)
  ) u_timebase (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick_r  (tick)
  );

  // Register write and read-back.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sink1_to_4_off_time_r <= `LSOT_OFF_TIME_RESET;
      reg_rdata_r           <= `LSOT_RDATA_IDLE;
    end
    else
    begin
      if (reg_we && (reg_addr == `LSOT_OFF_TIME_ADDR))
        sink1_to_4_off_time_r <= reg_wdata;
      // Reads of any other address return idle data; there is no error response.
      if (reg_re && (reg_addr == `LSOT_OFF_TIME_ADDR))
        reg_rdata_r <= sink1_to_4_off_time_r;
      else
        reg_rdata_r <= `LSOT_RDATA_IDLE;
    end
  end

  // A tick can fall in the entry cycle, so the first tick of an interval is partial.
  genvar g;
  generate
    for (g = 0; g < NUM_SINKS; g = g + 1)
    begin : g_sink
      reg  [`LSOT_ST_W-1:0]   st_r;
      reg  [`LSOT_ST_W-1:0]   st_nxt;
      reg  [`LSOT_CNT_W-1:0]  cnt_r;
      reg  [`LSOT_CNT_W-1:0]  cnt_nxt;
      wire [`LSOT_CODE_W-1:0] code;

      assign code = sink_code(sink1_to_4_off_time_r, g);

      always @*
      begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        if (!sink_enable[g])
        begin
          st_nxt  = ST_IDLE;
          cnt_nxt = CNT_ZERO;
        end
        else
        begin
          case (st_r)
            ST_IDLE:
            begin
              // Enabled with code 00 holds here, sink on.
              if (code != `LSOT_OFF_DISABLED)
                st_nxt = ST_RAMP;
            end
            ST_RAMP:
            begin
              if (code == `LSOT_OFF_DISABLED)
                st_nxt = ST_IDLE;
              else if (ramp_up_done[g])
              begin
                // Zero on time skips the on phase and starts the off interval at once.
                if (shared_on_time_code == {`LSOT_ON_CODE_W{1'b0}})
                begin
                  st_nxt  = ST_OFF;
                  cnt_nxt = off_ticks(code);
                end
                else
                begin
                  st_nxt  = ST_ON;
                  cnt_nxt = {{(`LSOT_CNT_W-`LSOT_ON_CODE_W){1'b0}}, shared_on_time_code};
                end
              end
            end
            ST_ON:
            begin
              if (code == `LSOT_OFF_DISABLED)
                st_nxt = ST_IDLE;
              else if (tick)
              begin
                if (cnt_r <= CNT_ONE)
                begin
                  st_nxt  = ST_OFF;
                  cnt_nxt = off_ticks(code);
                end
                else
                  cnt_nxt = cnt_r - CNT_ONE;
              end
            end
            ST_OFF:
            begin
              // The code latched at entry runs to completion.
              if (tick)
              begin
                if (cnt_r <= CNT_ONE)
                begin
                  st_nxt  = ST_RAMP;
                  cnt_nxt = CNT_ZERO;
                end
                else
                  cnt_nxt = cnt_r - CNT_ONE;
              end
            end
            default:
            begin
              st_nxt  = ST_IDLE;
              cnt_nxt = CNT_ZERO;
            end
          endcase
        end
      end

      // Next output levels; all sinks are registered together below.
      assign on_nxt[g]  = sink_enable[g] && (st_nxt != ST_OFF);
      assign off_nxt[g] = (st_nxt == ST_OFF);

      always @(posedge ref_clk)
      begin
        if (rst)
        begin
          st_r  <= ST_IDLE;
          cnt_r <= CNT_ZERO;
        end
        else
        begin
          st_r  <= st_nxt;
          cnt_r <= cnt_nxt;
        end
      end
    end
  endgenerate

  // One process drives each output vector, straight from its flip-flops.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sink_on_r        <= {NUM_SINKS{1'b0}};
      sink_off_phase_r <= {NUM_SINKS{1'b0}};
    end
    else
    begin
      sink_on_r        <= on_nxt;
      sink_off_phase_r <= off_nxt;
    end
  end

endmodule // lsot_off_timer

// file: lsot_map.vh
`ifndef LSOT_MAP_VH
`define LSOT_MAP_VH

// Register map.
`define LSOT_ADDR_W          8
`define LSOT_DATA_W          8
`define LSOT_OFF_TIME_ADDR   8'h1D
`define LSOT_OFF_TIME_RESET  8'h00
`define LSOT_RDATA_IDLE      8'h00

// Per-sink off-time code fields.
`define LSOT_SINK1_LSB       0
`define LSOT_SINK2_LSB       2
`define LSOT_SINK3_LSB       4
`define LSOT_SINK4_LSB       6
`define LSOT_CODE_W          2

// Off-time code values.
`define LSOT_OFF_DISABLED    2'h0
`define LSOT_OFF_0P6         2'h1
`define LSOT_OFF_1P2         2'h2
`define LSOT_OFF_1P8         2'h3

// Time base: one tick per on-time step of 0.05 s.
`define LSOT_CLK_PERIOD_NS   10
`define LSOT_TICK_NS         50000000
`define LSOT_TICK_CYCLES     (`LSOT_TICK_NS / `LSOT_CLK_PERIOD_NS)

// Off times in time-base ticks: 0.6 s, 1.2 s, 1.8 s.
`define LSOT_OFF_TICKS_0P6   6'h0C
`define LSOT_OFF_TICKS_1P2   6'h18
`define LSOT_OFF_TICKS_1P8   6'h24
`define LSOT_CNT_W           6
`define LSOT_ON_CODE_W       4

// Phase states.
`define LSOT_ST_W            2

`endif

// file: lsot_timebase.v
`timescale 1ns/1ns
`include "lsot_map.vh"

module lsot_timebase #(
  parameter TICK_CYCLES = `LSOT_TICK_CYCLES,
  parameter CNT_W       = 23
) (
  // Clock and reset.
  input  wire ref_clk,
  input  wire rst,
  // Tick output.
  output reg  tick_r
);

  reg  [CNT_W-1:0] div_r;
  wire             wrap;

  assign wrap = (div_r == TICK_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});

  // Free-running divider producing one pulse per tick period.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_r  <= {CNT_W{1'b0}};
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= wrap;
      if (wrap)
        div_r <= {CNT_W{1'b0}};
      else
        div_r <= div_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // lsot_timebase

// file: lsot_off_timer_checker.sv
`timescale 1ns/1ns
module lsot_chk #(
  parameter TICK_CYCLES = 10
) (
  // Clock and reset.
  input wire       ref_clk,
  input wire       rst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_we,
  input wire       reg_re,
  input wire [7:0] reg_rdata_r,
  // Sink link.
  input wire [3:0] sink_enable,
  input wire [3:0] sink_on_r,
  input wire [3:0] sink_off_phase_r
);
  localparam int OFF_MIN = 11 * TICK_CYCLES;
  localparam int OFF_MAX = 36 * TICK_CYCLES + 2;
  reg [7:0] code_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always @(posedge ref_clk)
    code_r <= rst ? 8'h00 : (reg_we && reg_addr == 8'h1D) ? reg_wdata : code_r;
  sequence wr_s; reg_we && reg_addr == 8'h1D; endsequence
  sequence rd_s; reg_re && reg_addr == 8'h1D; endsequence
  read_back_a: assert property (wr_s ##1 rd_s |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("read back");
  read_idle_a: assert property (!reg_re |=> reg_rdata_r == 8'h00)
    else $error("read idle");
  read_unmap_a: assert property (reg_re && reg_addr != 8'h1D |=> reg_rdata_r == 8'h00)
    else $error("unmapped read");
  enable_gate_a: assert property (
    1 |=> ((sink_on_r | sink_off_phase_r) & ~$past(sink_enable)) == 4'h0) else $error("gate");
  code_hold_a: assert property (
    sink_enable[3] && code_r[7:6] == 2'h0 && !sink_off_phase_r[3] |=> sink_on_r[3])
    else $error("no steady on");
  off_min_a: assert property ($rose(sink_off_phase_r[0]) |-> ##OFF_MIN sink_off_phase_r[0])
    else $error("off too short");
  off_end_a: assert property (
    $rose(sink_off_phase_r[0]) |-> ##[1:OFF_MAX] !sink_off_phase_r[0]) else $error("off long");
  off_exit_a: assert property (
    $fell(sink_off_phase_r[0]) && $past(sink_enable[0]) |-> sink_on_r[0]) else $error("no on");
endmodule // lsot_chk

bind lsot_off_timer lsot_chk #(.TICK_CYCLES(TICK_CYCLES)) u_lsot_chk (.ref_clk, .rst, .reg_addr,
  .reg_wdata, .reg_we, .reg_re, .reg_rdata_r, .sink_enable, .sink_on_r, .sink_off_phase_r);

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  reg        ref_clk = 1'b0;
  reg        rst = 1'b1;
  reg        reg_we = 1'b0;
  reg        reg_re = 1'b0;
  reg  [7:0] reg_addr = 8'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg  [3:0] sink_enable = 4'h0;
  reg  [3:0] on_code = 4'h0;
  reg  [3:0] ramp_done = 4'hF;
  wire [7:0] reg_rdata_r;
  wire [3:0] sink_on_r;
  wire [3:0] sink_off_phase_r;
  integer    n_errors = 0;
  integer    n_compared = 0;
  integer    i, g;
  integer    len, t;
  integer    off_n [0:3];
  integer    on_n [0:3];
  // Row: address, write data, read there, read of the off-time register.
  reg [31:0] rows [0:2] = '{32'h1D1B1B1B, 32'h1DE4E4E4, 32'h1C5500E4};

  lsot_off_timer #(.TICK_CYCLES(10)) u_lsot_off_timer (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_we, .reg_re, .reg_rdata_r, .shared_on_time_code(on_code), .sink_enable,
    .ramp_up_done(ramp_done), .sink_on_r, .sink_off_phase_r);

  initial forever #5 ref_clk = ~ref_clk;

  task results;
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input [7:0] seen, input [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task acc(input w, input r, input [7:0] a, input [7:0] d);
    @(negedge ref_clk);
    reg_we = w;
    reg_re = r;
    reg_addr = a;
    reg_wdata = d;
  endtask

  task rd(input [7:0] a, input [7:0] exp);
    acc(1'b0, 1'b1, a, 8'h00);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    chk(reg_rdata_r, exp);
  endtask

  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    begin : body
      rd(8'h1D, 8'h00);
      for (i = 0; i < 3; i = i + 1)
      begin
        acc(1'b1, 1'b0, rows[i][31:24], rows[i][23:16]);
        rd(rows[i][31:24], rows[i][15:8]);
        rd(8'h1D, rows[i][7:0]);
      end
      // Sink 1 to 4 get codes 11, 10, 01 and 00 with zero on time.
      acc(1'b1, 1'b0, 8'h1D, 8'h1B);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      sink_enable = 4'hF;
      for (g = 0; g < 4; g = g + 1)
      begin
        off_n[g] = 0;
        on_n[g] = 0;
      end
      repeat (400)
      begin
        @(negedge ref_clk);
        for (g = 0; g < 4; g = g + 1)
          if (sink_off_phase_r[g] && on_n[g] == 0)
            off_n[g] = off_n[g] + 1;
          else if (off_n[g] > 0 && !sink_off_phase_r[g])
            on_n[g] = on_n[g] + 1;
      end
      for (g = 0; g < 4; g = g + 1)
        chk(8'((off_n[g] + 9) / 10), 8'(12 * (3 - g)));
      chk(8'(on_n[0] < 4), 8'h01);
      chk({7'h00, sink_on_r[3]}, 8'h01);
      sink_enable = 4'hB;
      @(negedge ref_clk);
      chk({6'h00, sink_on_r[2], sink_off_phase_r[2]}, 8'h00);
      // Sink 1 gets code 01 while still off on code 11, and three ticks of on time.
      on_code = 4'h3;
      acc(1'b1, 1'b0, 8'h1D, 8'h01);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      for (i = 0; i < 400 && !sink_off_phase_r[0]; i = i + 1)
        @(negedge ref_clk);
      for (g = 0; g < 400 && sink_off_phase_r[0]; g = g + 1)
        @(negedge ref_clk);
      for (len = 0; len < 100 && !sink_off_phase_r[0]; len = len + 1)
        @(negedge ref_clk);
      for (t = 0; t < 400 && sink_off_phase_r[0]; t = t + 1)
        @(negedge ref_clk);
      if (i == 400 || g == 400 || len == 100 || t == 400)
      begin
        $display("BAD %0t timeout waiting for sink 1", $time);
        n_errors = n_errors + 1;
        disable body;
      end
      // The lit stretch is one ramp cycle plus three ticks, the first one partial.
      chk(8'((len + 8) / 10), 8'h03);
      chk(8'((t + 9) / 10), 8'h0C);
      // Without a finished ramp the sink waits, lit, in its ramp phase.
      ramp_done = 4'h0;
      repeat (50) @(negedge ref_clk);
      chk({6'h00, sink_on_r[0], sink_off_phase_r[0]}, 8'h02);
    end
    results;
  end
endmodule // tb_top
